// ---- inc/cct_defines.svh ----
// Constants for the clamp, blanking and vertical timing block
`ifndef CCT_DEFINES_SVH
`define CCT_DEFINES_SVH

// ----------------------------------------------------------------
// Widths
// ----------------------------------------------------------------
`define CCT_PIX_W        12
`define CCT_REF_W        10
`define CCT_EXT_W        9
`define CCT_LINE_W       11
`define CCT_BND_W        8
`define CCT_VPOS_W       9
`define CCT_REP_W        4
`define CCT_REGIONS      5

// ----------------------------------------------------------------
// Timing counts and codes
// ----------------------------------------------------------------
`define CCT_SETUP_CYC    12'h004
`define CCT_HPULSE_GAP   10'h002
`define CCT_PTR_EVEN01   3'h4
`define CCT_PTR_EVEN23   3'h5

`endif

// ---- inc/cct_pkg.sv ----
// Types and helper functions for the clamp, blanking and vertical timing block
`include "cct_defines.svh"

package cct_pkg;

  // ----------------------------------------------------------------
  // One vertical transfer pattern
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [`CCT_VPOS_W-1:0]      repeatSpacing;  // Pixels between repetitions
    logic [3:0]                  startPolarity;  // Per phase start level
    logic [3:0][`CCT_VPOS_W-1:0] toggleFirst;    // Per phase first toggle
    logic [3:0][`CCT_VPOS_W-1:0] toggleSecond;   // Per phase second toggle
    logic [`CCT_REP_W-1:0]       repeatCount;    // Repetitions per line
  } cct_pat_s;

  // ----------------------------------------------------------------
  // Whole configuration, driven on the cfg input port
  // ----------------------------------------------------------------
  typedef struct packed {
    logic                         blackClampOn;
    logic                         clampRegionOverride;
    logic                         blankingMaskPolarity;
    logic                         blankingRetimeEnable;
    logic                         blankingPulseOutput;
    logic                         blankingExtendEnable;
    logic                         gateShutterSelect;
    logic [`CCT_PIX_W-1:0]        lineLengthSetting;   // Gray code
    logic [`CCT_PIX_W-1:0]        finalLineLength;     // Gray code
    logic [`CCT_PIX_W-1:0]        clampToggleFirst;    // Gray code
    logic [`CCT_PIX_W-1:0]        clampToggleSecond;   // Gray code
    logic [`CCT_REGIONS-1:0]      clampRegionEnable;
    logic [`CCT_REF_W-1:0]        blankingPulsePosition;
    logic [`CCT_EXT_W-1:0]        extensionLength;
    logic [`CCT_REF_W-1:0]        hdRisePosition;
    logic [`CCT_LINE_W-1:0]       fieldLines;
    logic [3:0][`CCT_BND_W-1:0]   regionBoundaryLine;  // Regions 1 to 4
    logic [4:0][2:0]              regionSequencePointer;
    logic [3:0][1:0]              patternSelectEntry;
    cct_pat_s [3:0]               pattern;
  } cct_cfg_s;

  // Gray code to binary
  function automatic logic [`CCT_PIX_W-1:0] cct_gray2bin(input logic [`CCT_PIX_W-1:0] g);
    logic [`CCT_PIX_W-1:0] b;
    b[`CCT_PIX_W-1] = g[`CCT_PIX_W-1];
    for (int i = `CCT_PIX_W-2; i >= 0; i--) begin
      b[i] = b[i+1] ^ g[i];
    end
    return b;
  endfunction : cct_gray2bin

  // Binary to Gray code
  function automatic logic [`CCT_PIX_W-1:0] cct_bin2gray(input logic [`CCT_PIX_W-1:0] b);
    return b ^ (b >> 1);
  endfunction : cct_bin2gray

endpackage : cct_pkg

// ---- design/cct_timing.sv ----
// Clamp placement, horizontal blanking and vertical pattern generator
`timescale 1ns/1ps
`default_nettype none
`include "cct_defines.svh"

module cct_timing (
  input  wire logic             mclk,
  input  wire logic             rst_n,
  input  wire cct_pkg::cct_cfg_s cfg,
  input  wire logic             externalGateInput,
  input  wire logic             mechanicalShutterSignal,
  output var  logic             blackClampPulse,
  output var  logic             horizontalClockA,
  output var  logic             horizontalClockB,
  output var  logic             horizontalDrive,
  output var  logic             verticalDrive,
  output var  logic [3:0]       verticalPhase
);
  import cct_pkg::*;

  // ----------------------------------------------------------------
  // Local functions
  // ----------------------------------------------------------------

  // Region of a line: last boundary passed, region 0 from line 0
  function automatic logic [2:0] regionOf(input logic [`CCT_LINE_W-1:0] line,
                                          input logic [3:0][`CCT_BND_W-1:0] bnd);
    logic [2:0] r;
    r = 3'h0;
    for (int i = 0; i < 4; i++) begin
      if ({3'h0, bnd[i]} <= line) begin
        r = 3'(i + 1);
      end
    end
    return r;
  endfunction : regionOf

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic                     gateMeta;       // Synchroniser stage one
  logic                     gateSync;       // Synchroniser stage two
  logic                     gateLatched;    // Gate caught at drive fall
  logic [`CCT_PIX_W-1:0]    pixCnt;         // Horizontal pixel counter
  logic [`CCT_REF_W-1:0]    lineRef;        // Line reference counter
  logic [`CCT_EXT_W-1:0]    extCnt;         // Extension counter
  logic [`CCT_LINE_W-1:0]   lineCnt;        // Line within field
  logic                     holdoff;        // First line after disabled region
  logic                     clampWin;       // Raw clamp window
  logic                     blankDly;       // Retimed blanking
  logic [`CCT_VPOS_W-1:0]   vCnt;           // Pixel within repetition
  logic [`CCT_REP_W-1:0]    repCnt;         // Repetitions done
  logic                     lastLine;       // Final line of field
  logic [`CCT_PIX_W-1:0]    lenNow;         // Pixels in this line, minus one
  logic                     extActive;      // Pixel and reference counters paused
  logic                     lineEnd;        // Last pixel of line
  logic [`CCT_LINE_W-1:0]   next_lineCnt;   // Line after this one
  logic [2:0]               region;         // Current region
  logic [2:0]               nextRegion;     // Region of next line
  logic                     lastBad;        // Final line length differs
  logic                     gateMask;       // Gate masking active
  logic                     clampAllow;     // Clamp gating result
  logic                     next_clampWin;  // Window after this cycle
  logic                     next_hd;        // Horizontal drive next
  logic                     blankRaw;       // Unretimed blanking
  logic                     blankUse;       // Blanking actually used
  logic                     pulseHit;       // Selective pulse pixel
  logic                     next_hA;        // Clock A next
  logic [2:0]               ptr;            // Sequence pointer of region
  logic [1:0]               sel;            // Chosen pattern number
  cct_pat_s                 pat;            // Chosen pattern
  logic                     repsDone;       // All repetitions emitted
  logic [3:0]               next_vPhase;    // Vertical phases next

  // ----------------------------------------------------------------
  // Gate pin synchroniser
  // ----------------------------------------------------------------

  // Pin is asynchronous to mclk, two stages before any use
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      gateMeta <= 1'b0;
      gateSync <= 1'b0;
    end else begin
      gateMeta <= externalGateInput;
      gateSync <= gateMeta;
    end
  end

  // ----------------------------------------------------------------
  // Line timing decode
  // ----------------------------------------------------------------

  // Line length counts the four setup cycles on top of the setting
  always_comb begin
    lastLine     = (lineCnt == (cfg.fieldLines - 11'h001));
    lenNow       = (lastLine ? cct_gray2bin(cfg.finalLineLength)
                             : cct_gray2bin(cfg.lineLengthSetting))
                   + (`CCT_SETUP_CYC - 12'h001);
    extActive    = (extCnt != 9'h000);
    lineEnd      = !extActive && (pixCnt == lenNow);
    next_lineCnt = lastLine ? 11'h000 : lineCnt + 11'h001;
    region       = regionOf(lineCnt, cfg.regionBoundaryLine);
    nextRegion   = regionOf(next_lineCnt, cfg.regionBoundaryLine);
  end

  // ----------------------------------------------------------------
  // Pixel, reference and extension counters
  // ----------------------------------------------------------------

  // Extension freezes both pixel counters at zero for its length
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      pixCnt  <= '0;
      lineRef <= '0;
      extCnt  <= '0;
    end else if (lineEnd) begin
      pixCnt  <= '0;
      lineRef <= '0;
      extCnt  <= cfg.blankingExtendEnable ? cfg.extensionLength : 9'h000;
    end else if (extActive) begin
      extCnt  <= extCnt - 9'h001;
    end else begin
      pixCnt  <= pixCnt + 12'h001;
      lineRef <= lineRef + 10'h001;
    end
  end

  // Line counter and region holdoff, both move at line end
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      lineCnt <= '0;
      holdoff <= 1'b0;
    end else if (lineEnd) begin
      lineCnt <= next_lineCnt;
      // Disabled region keeps clamp off one more line
      holdoff <= (nextRegion != region) && !cfg.clampRegionEnable[region];
    end
  end

  // Gate caught at each fall of horizontal drive
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      gateLatched <= 1'b0;
    end else if (lineEnd) begin
      gateLatched <= gateSync;
    end
  end

  // ----------------------------------------------------------------
  // Clamp pulse
  // ----------------------------------------------------------------
  always_comb begin
    // Window opens and closes on Gray matches of the pixel counter
    next_clampWin = clampWin;
    if (cct_bin2gray(pixCnt) == cfg.clampToggleFirst) begin
      next_clampWin = 1'b1;
    end
    if (cct_bin2gray(pixCnt) == cfg.clampToggleSecond) begin
      next_clampWin = 1'b0;
    end
    lastBad    = lastLine && (cfg.finalLineLength != cfg.lineLengthSetting);
    // Shutter low shields the outputs from the gate
    gateMask   = gateLatched && (!cfg.gateShutterSelect || mechanicalShutterSignal);
    clampAllow = cfg.blackClampOn
                 && (cfg.clampRegionOverride
                     || (cfg.clampRegionEnable[region] && !holdoff))
                 && !lastBad && !gateMask;
  end

  // Clamp window and gated output
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      clampWin        <= 1'b0;
      blackClampPulse <= 1'b0;
    end else begin
      clampWin        <= next_clampWin;
      blackClampPulse <= next_clampWin && clampAllow;
    end
  end

  // ----------------------------------------------------------------
  // Horizontal drive and clocks
  // ----------------------------------------------------------------
  always_comb begin
    // Drive low from line start, and through any extension
    next_hd  = !lineEnd && !extActive && (lineRef >= cfg.hdRisePosition);
    blankRaw = !next_hd;
    blankUse = cfg.blankingRetimeEnable ? blankDly : blankRaw;
    // Two pulses, a fixed gap apart, only in selective mode
    pulseHit = cfg.blankingPulseOutput
               && ((lineRef == cfg.blankingPulsePosition)
                   || (lineRef == cfg.blankingPulsePosition + `CCT_HPULSE_GAP));
    if (blankUse) begin
      next_hA = pulseHit ? !cfg.blankingMaskPolarity
                         : cfg.blankingMaskPolarity;
    end else begin
      next_hA = !horizontalClockA;
    end
  end

  // Retime costs one cycle of blanking delay against a clean edge
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      blankDly <= 1'b1;
    end else begin
      blankDly <= blankRaw;
    end
  end

  // Drive outputs; clock B built from the same next value as A
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      horizontalDrive  <= 1'b0;
      verticalDrive    <= 1'b0;
      horizontalClockA <= 1'b0;
      horizontalClockB <= 1'b1;
    end else begin
      horizontalDrive  <= next_hd;
      verticalDrive    <= (next_lineCnt != 11'h000) || !lineEnd
                          ? (lineEnd || lineCnt != 11'h000) : 1'b0;
      horizontalClockA <= next_hA;
      horizontalClockB <= !next_hA;
    end
  end

  // ----------------------------------------------------------------
  // Vertical pattern selection
  // ----------------------------------------------------------------
  always_comb begin
    ptr = cfg.regionSequencePointer[region];
    unique case (ptr)
      `CCT_PTR_EVEN01: sel = cfg.patternSelectEntry[{1'b0, lineCnt[0]}];
      `CCT_PTR_EVEN23: sel = cfg.patternSelectEntry[{1'b1, lineCnt[0]}];
      default:         sel = cfg.patternSelectEntry[ptr[1:0]];
    endcase
    pat      = cfg.pattern[sel];
    // Count at or past target is done; a mid-line pattern swap must not restart pulses
    repsDone = (repCnt >= pat.repeatCount);
    for (int i = 0; i < 4; i++) begin
      // Level flips once at each toggle position
      next_vPhase[i] = pat.startPolarity[i]
                       ^ (!repsDone && ((vCnt >= pat.toggleFirst[i])
                                        ^ (vCnt >= pat.toggleSecond[i])));
    end
    if (gateMask) begin
      next_vPhase = pat.startPolarity;
    end
  end

  // Repetition counters restart on every line
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      vCnt   <= '0;
      repCnt <= '0;
    end else if (lineEnd) begin
      vCnt   <= '0;
      repCnt <= '0;
    end else if (!repsDone) begin
      if (vCnt == pat.repeatSpacing - 9'h001) begin
        vCnt   <= '0;
        repCnt <= repCnt + 4'h1;
      end else begin
        vCnt   <= vCnt + 9'h001;
      end
    end
  end

  // Vertical phase outputs
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      verticalPhase <= 4'h0;
    end else begin
      verticalPhase <= next_vPhase;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  sequence extHoldS;
    (pixCnt == 12'h000) && !horizontalDrive;
  endsequence

  clamp_off_a: assert property (@(posedge mclk) disable iff (!rst_n)
    !cfg.blackClampOn |=> !blackClampPulse)
    else $error("Clamp seen while clamp is switched off");

  clock_inverse_a: assert property (@(posedge mclk) disable iff (!rst_n)
    horizontalClockB == !horizontalClockA)
    else $error("Clock B is not the inverse of clock A");

  blank_level_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (!cfg.blankingRetimeEnable && !cfg.blankingPulseOutput && !next_hd)
    |=> (horizontalClockA == $past(cfg.blankingMaskPolarity)) && !horizontalDrive)
    else $error("Clock A not held at mask level while blanked");

  last_line_a: assert property (@(posedge mclk) disable iff (!rst_n)
    lastBad |=> !blackClampPulse)
    else $error("Clamp on a final line of different length");

  gate_mask_a: assert property (@(posedge mclk) disable iff (!rst_n)
    gateMask |=> !blackClampPulse && (verticalPhase == $past(pat.startPolarity)))
    else $error("Gate mask did not hold clamp and vertical phases");

  shutter_block_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (cfg.gateShutterSelect && !mechanicalShutterSignal && gateLatched && cfg.blackClampOn
     && (&cfg.clampRegionEnable) && !holdoff && !lastBad && next_clampWin)
    |=> blackClampPulse)
    else $error("Gate masked while shutter signal low");

  drive_fall_a: assert property (@(posedge mclk) disable iff (!rst_n)
    lineEnd |=> !horizontalDrive && (pixCnt == 12'h000))
    else $error("Horizontal drive not low at line start");

  zero_repeat_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (pat.repeatCount == 4'h0 && !gateMask) |=> verticalPhase == $past(pat.startPolarity))
    else $error("Zero repeat count did not hold start polarity");

  extend_hold_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (lineEnd && cfg.blankingExtendEnable && cfg.extensionLength >= 9'h002)
    |=> extHoldS ##1 extHoldS)
    else $error("Extension did not pause the counters");

  // Holdoff line keeps the clamp quiet even when the new region is enabled
  holdoff_block_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (holdoff && !cfg.clampRegionOverride) |=> !blackClampPulse)
    else $error("Clamp in the first line after a disabled region");

  // Selective pulse: clock A leaves the mask level for one cycle
  sequence pulseOutS;
    horizontalClockA == !$past(cfg.blankingMaskPolarity);
  endsequence

  select_pulse_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (pulseHit && blankUse) |=> pulseOutS)
    else $error("Selective blanking pulse missing");

  // Field restarts in region zero at the drive fall
  field_start_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (lineEnd && lastLine) |=> !verticalDrive && (lineCnt == 11'h000))
    else $error("Vertical drive not low at field start");

endmodule : cct_timing

`default_nettype wire

// ---- sim/cct_ccd_model.sv ----
// Sensor stand-in that measures line period, clamp width and H clock pairing
`timescale 1ns/1ps
`default_nettype none

module cct_ccd_model (
  input  wire logic        mclk,
  input  wire logic        rst_n,
  input  wire logic        blackClampPulse,
  input  wire logic        horizontalClockA,
  input  wire logic        horizontalClockB,
  input  wire logic        horizontalDrive,
  output var  logic [15:0] linePeriod,
  output var  logic [15:0] clampCycles,
  output var  logic [15:0] pairErrors
);
  logic [15:0] pixCount;  // Cycles since the last line start
  logic [15:0] clampRun;  // Clamp cycles seen in the current line
  logic        prevDrive; // Drive level one cycle ago

  // ----------------------------------------------------------------
  // Line and clamp measurement
  // ----------------------------------------------------------------
  // Results are latched at each drive fall, so the bench reads whole lines only
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      pixCount    <= 16'h0000;
      clampRun    <= 16'h0000;
      prevDrive   <= 1'b0;
      linePeriod  <= 16'h0000;
      clampCycles <= 16'h0000;
    end else begin
      prevDrive <= horizontalDrive;
      if (prevDrive && !horizontalDrive) begin
        linePeriod  <= pixCount;
        clampCycles <= clampRun;
        pixCount    <= 16'h0001;
        clampRun    <= {15'h0000, blackClampPulse};
      end else begin
        pixCount <= pixCount + 16'h0001;
        clampRun <= clampRun + {15'h0000, blackClampPulse};
      end
    end
  end

  // ----------------------------------------------------------------
  // Clock pair watch: both clocks equal would short the sensor's register
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      pairErrors <= 16'h0000;
    end else if (horizontalClockB !== ~horizontalClockA) begin
      pairErrors <= pairErrors + 16'h0001;
    end
  end
endmodule : cct_ccd_model

`default_nettype wire

// ---- sim/tb_cct_timing.sv ----
// Self-checking bench for the clamp, blanking and vertical timing block
`timescale 1ns/1ps
`default_nettype none

module tb_cct_timing;
  import cct_pkg::*;
  localparam int LINE = 40;  // Pixels per regular line
  logic        mclk, rst_n, gateIn, shutter, clamp, hA, hB, hd, vd;
  logic [3:0]  vPhase;        // Vertical phases one to four
  logic [15:0] linePeriod, clampCycles, pairErrors;
  cct_cfg_s    cfg;           // Whole register set, changed by the tasks mid-line
  int          fails, compares;

  cct_timing cct_timing_i (.mclk(mclk), .rst_n(rst_n), .cfg(cfg), .externalGateInput(gateIn),
    .mechanicalShutterSignal(shutter), .blackClampPulse(clamp), .horizontalClockA(hA),
    .horizontalClockB(hB), .horizontalDrive(hd), .verticalDrive(vd), .verticalPhase(vPhase));
  cct_ccd_model cct_ccd_model_i (.mclk(mclk), .rst_n(rst_n), .blackClampPulse(clamp),
    .horizontalClockA(hA), .horizontalClockB(hB), .horizontalDrive(hd),
    .linePeriod(linePeriod), .clampCycles(clampCycles), .pairErrors(pairErrors));

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [11:0] gray(input int v);
    return 12'(v ^ (v >> 1));
  endfunction : gray

  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    compares++;
    if (got !== exp) begin
      $display("Error %s expected %0h seen %0h", what, exp, got);
      fails++;
    end
  endtask : check

  task automatic wait_lines(input int n);
    repeat (n * LINE) @(negedge mclk);
  endtask : wait_lines

  // Clock A high cycles while drive is low, over one blanking period
  task automatic blank_highs(output int n);
    logic prev;
    n = 0;
    prev = 1'b0;
    for (int k = 0; k < 200 && !(prev && !hd); k++) begin
      prev = hd;
      @(negedge mclk);
    end
    for (int k = 0; k < 200 && !hd; k++) begin
      n += int'(hA);
      @(negedge mclk);
    end
  endtask : blank_highs

  // Cycles and clamp cycles of one whole field, from one drive fall to the next
  task automatic field_stats(output int p, output int c);
    logic prev;
    p = 0;
    c = 0;
    prev = 1'b0;
    while (!(prev && !vd) && p < 4000) begin
      prev = vd;
      @(negedge mclk);
      p++;
    end
    p = 0;
    do begin
      prev = vd;
      c += int'(clamp);
      @(negedge mclk);
      p++;
    end while (!(prev && !vd) && p < 4000);
  endtask : field_stats

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic test_line();
    wait_lines(4);
    check("line period", 16'h0028, linePeriod);
    cfg.blankingExtendEnable = 1'b1;
    cfg.extensionLength = 9'h003;
    wait_lines(4);
    check("extended period", 16'h002B, linePeriod);
    cfg.blankingExtendEnable = 1'b0;
    wait_lines(3);
    check("pair errors", 16'h0000, pairErrors);
    $display("test_line done");
  endtask : test_line

  task automatic test_blank();
    logic prev;
    for (int m = 0; m < 2; m++) begin
      cfg.blankingMaskPolarity = m[0];
      wait_lines(2);
      prev = 1'b0;
      for (int k = 0; k < 200 && !(prev && !hd); k++) begin
        prev = hd;
        @(negedge mclk);
      end
      @(negedge mclk);
      check("clock a blanked", {15'h0000, m[0]}, {15'h0000, hA});
      check("clock b blanked", {15'h0000, ~m[0]}, {15'h0000, hB});
    end
    $display("test_blank done");
  endtask : test_blank

  // Five blanked cycles: two pulses at lineRef 1 and 3; retime costs the first cycle
  task automatic test_select();
    int n;
    cfg.blankingMaskPolarity = 1'b0;
    cfg.blankingPulseOutput = 1'b1;
    cfg.blankingPulsePosition = 10'h001;
    wait_lines(2);
    blank_highs(n);
    check("selective pulses", 16'h0002, 16'(n));
    cfg.blankingPulseOutput = 1'b0;
    cfg.blankingMaskPolarity = 1'b1;
    wait_lines(2);
    blank_highs(n);
    check("blank highs", 16'h0005, 16'(n));
    cfg.blankingRetimeEnable = 1'b1;
    wait_lines(2);
    blank_highs(n);
    check("retimed highs", 16'h0004, 16'(n));
    cfg.blankingRetimeEnable = 1'b0;
    $display("test_select done");
  endtask : test_select

  // Row k: on bit off only for k 1, override for k 0 and 1, enables set for k 3
  task automatic test_clamp();
    for (int k = 0; k < 4; k++) begin
      cfg.blackClampOn = (k != 1);
      cfg.clampRegionOverride = (k < 2);
      cfg.clampRegionEnable = {5{k == 3}};
      wait_lines(4);
      check("clamp width", (k == 0 || k == 3) ? 16'h0006 : 16'h0000, clampCycles);
    end
    $display("test_clamp done");
  endtask : test_clamp

  task automatic test_gate();
    gateIn = 1'b1;
    wait_lines(4);
    check("gated clamp", 16'h0000, clampCycles);
    cfg.gateShutterSelect = 1'b1;
    wait_lines(4);
    check("shutter low clamp", 16'h0006, clampCycles);
    shutter = 1'b1;
    wait_lines(4);
    check("shutter high clamp", 16'h0000, clampCycles);
    gateIn = 1'b0;
    shutter = 1'b0;
    wait_lines(4);
    $display("test_gate done");
  endtask : test_gate

  // A last line four pixels longer than the rest must carry no clamp
  task automatic test_last();
    int p, c;
    cfg.finalLineLength = gray(LINE);
    field_stats(p, c);
    field_stats(p, c);
    check("field clamp", 16'(((p - LINE - 4) / LINE) * 6), 16'(c));
    check("field period", 16'(8 * LINE + 4), 16'(p));
    cfg.finalLineLength = gray(LINE - 4);
    $display("test_last done");
  endtask : test_last

  // Region one off: lines 2 and 3 and the first line of region two lose the clamp
  task automatic test_hold();
    int p, c;
    cfg.clampRegionEnable = 5'h1D;
    field_stats(p, c);
    field_stats(p, c);
    check("held clamp lines", 16'h001E, 16'(c));
    cfg.clampRegionEnable = 5'h1F;
    $display("test_hold done");
  endtask : test_hold

  task automatic test_vert();
    int n;
    cfg.regionSequencePointer = {5{3'h1}};
    cfg.patternSelectEntry[1] = 2'h2;
    cfg.pattern[2].repeatCount = 4'h1;
    wait_lines(3);
    n = 0;
    repeat (LINE) begin
      @(negedge mclk);
      n += int'(vPhase === 4'hF);
    end
    check("pulse width", 16'h0005, 16'(n));
    cfg.pattern[2].repeatCount = 4'h0;
    cfg.pattern[2].startPolarity = 4'hA;
    wait_lines(3);
    n = 0;
    repeat (LINE) begin
      @(negedge mclk);
      n += int'(vPhase === 4'hA);
    end
    check("held polarity", 16'h0028, 16'(n));
    cfg.regionSequencePointer = {5{3'h4}};
    cfg.patternSelectEntry = {2'h0, 2'h0, 2'h0, 2'h2};
    wait_lines(3);
    n = 0;
    repeat (2 * LINE) begin
      @(negedge mclk);
      n += int'(vPhase === 4'hA);
    end
    check("even line pattern", 16'h0028, 16'(n));
    $display("test_vert done");
  endtask : test_vert

  task automatic final_report();
    $display("Comparisons %0d mismatches %0d", compares, fails);
    if (fails == 0 && compares > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : final_report

  // ----------------------------------------------------------------
  // Clock, watchdog and main sequence
  // ----------------------------------------------------------------
  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end

  // Tests need about 5000 cycles; four times that means a hang
  initial begin
    repeat (20000) @(posedge mclk);
    fails++;
    final_report();
  end

  initial begin
    rst_n = 1'b0;
    gateIn = 1'b0;
    shutter = 1'b0;
    cfg = '0;
    cfg.lineLengthSetting = gray(LINE - 4);
    cfg.finalLineLength = gray(LINE - 4);
    cfg.clampToggleFirst = gray(10);
    cfg.clampToggleSecond = gray(16);
    cfg.blackClampOn = 1'b1;
    cfg.clampRegionOverride = 1'b1;
    cfg.hdRisePosition = 10'h004;
    cfg.fieldLines = 11'h008;
    cfg.regionBoundaryLine = {8'h07, 8'h06, 8'h04, 8'h02};
    cfg.pattern[2].repeatSpacing = 9'h014;
    cfg.pattern[2].toggleFirst = {4{9'h005}};
    cfg.pattern[2].toggleSecond = {4{9'h00A}};
    repeat (16) @(negedge mclk);
    check("reset outputs", 16'h0040, {7'h00, clamp, hA, hB, hd, vd, vPhase});
    rst_n = 1'b1;
    test_line();
    test_blank();
    test_select();
    test_clamp();
    test_gate();
    test_last();
    test_hold();
    test_vert();
    final_report();
  end
endmodule : tb_cct_timing

`default_nettype wire
